// ===== sfs_front.sv
// Purpose: serial slave front end of a serial flash memory
// Assumes: link pins are asynchronous and sampled by clock_in
// Notes:   array operations are outside; opcodes are reported out
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"
module sfs_front (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	// serial link pins
	input  wire logic       device_select_n_in,
	input  wire logic       serial_clock_in,
	input  wire logic       serial_in_in,
	input  wire logic       pause_n_in,
	input  wire logic       write_guard_n_in,
	output logic            serial_out_out,
	output logic            serial_out_oe_out,
	// core side
	input  wire logic       busy_in,
	input  wire logic [7:0] read_data_in,
	output logic [7:0]      opcode_out,
	output logic            opcode_valid_out,
	output logic [7:0]      byte_out,
	output logic            byte_valid_out,
	output logic            read_req_out,
	output logic [7:0]      status_out,
	output logic            status_write_out,
	output logic            paused_out
);
	import sfs_pkg::*;

	typedef struct packed {
		logic          sck_prev;
		logic          sel_prev;
		logic          pause_prev;
		logic          guard_prev;
		logic          paused;
		sfs_phase_type phase;
		logic [2:0]    bit_count;
		logic [7:0]    shift_in;
		logic [7:0]    opcode;
		logic [7:0]    shift_out;
		logic          out_bit;
		logic          out_en;
		logic          wsr_ok;
		logic          wsr_got;
		logic [7:0]    status;
		logic          status_write;
		logic          opcode_valid;
		logic [7:0]    byte_data;
		logic          byte_valid;
		logic          read_req;
	} sfs_state_type;

	sfs_state_type state;
	sfs_state_type next_state;

	logic [4:0] pins;
	logic       sel_n;
	logic       sck;
	logic       sin;
	logic       pause_n;
	logic       guard_n;

	sfs_sync #(
		.WIDTH (5),
		.IDLE  (`SFS_PIN_IDLE)
	) u_sync (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.async_in ({device_select_n_in, serial_clock_in, serial_in_in,
		            pause_n_in, write_guard_n_in}),
		.sync_out (pins)
	);

	assign sel_n = pins[4];
	assign sck = pins[3];
	assign sin = pins[2];
	assign pause_n = pins[1];
	assign guard_n = pins[0];

	logic sck_rise;
	logic sck_fall;
	logic sel_fall;
	logic guard_fall;
	logic shifting;
	logic known_op;
	logic guarded;
	logic [7:0] in_byte;

	function automatic logic is_known(input logic [7:0] op);
		unique case (op)
			`SFS_OP_WR_ENABLE, `SFS_OP_WR_DISABLE, `SFS_OP_RD_STATUS,
			`SFS_OP_WR_STATUS, `SFS_OP_READ, `SFS_OP_FAST_READ,
			`SFS_OP_PROGRAM, `SFS_OP_PAGE_ERASE, `SFS_OP_SECT_ERASE,
			`SFS_OP_BULK_ERASE, `SFS_OP_SW_PROTECT,
			`SFS_OP_RELEASE: is_known = 1'b1;
			default: is_known = 1'b0;
		endcase
	endfunction : is_known

	always_comb begin
		sck_rise = sck & ~state.sck_prev;
		sck_fall = ~sck & state.sck_prev;
		sel_fall = ~sel_n & state.sel_prev;
		guard_fall = ~guard_n & state.guard_prev;
		// serial activity only while selected and not paused
		shifting = ~sel_n & ~state.paused;
		in_byte = {state.shift_in[6:0], sin};
		known_op = is_known(in_byte);
		// pin acts only with the enable bit set
		guarded = ~guard_n & state.status[`SFS_GUARD_EN_BIT];
	end

	always_comb begin
		next_state = state;
		next_state.sck_prev = sck;
		next_state.sel_prev = sel_n;
		next_state.pause_prev = pause_n;
		next_state.guard_prev = guard_n;
		next_state.opcode_valid = 1'b0;
		next_state.byte_valid = 1'b0;
		next_state.read_req = 1'b0;
		next_state.status_write = 1'b0;
		next_state.status[`SFS_BUSY_BIT] = busy_in;

		// while selected, pause enter/leave only when the serial clock is low
		if (sel_n) begin
			next_state.paused = 1'b0;
		end else if (~sck) begin
			next_state.paused = ~pause_n;
		end

		if (sel_n) begin
			// fresh command on next selection
			next_state.phase = SFS_OPCODE;
			next_state.bit_count = 3'h0;
			next_state.opcode = 8'h00;
			next_state.out_en = 1'b0;
			next_state.wsr_ok = 1'b0;
			next_state.wsr_got = 1'b0;
			// deselect ends a complete status write
			if (state.wsr_got && state.wsr_ok) begin
				next_state.status_write = 1'b1;
			end
		end else if (sel_fall) begin
			next_state.phase = SFS_OPCODE;
			next_state.bit_count = 3'h0;
		end else if (shifting) begin
			if (sck_rise && state.phase != SFS_REJECT) begin
				next_state.shift_in = in_byte;
				next_state.bit_count = state.bit_count + 3'h1;
				if (state.bit_count == 3'h7) begin
					if (state.phase == SFS_OPCODE) begin
						next_state.opcode = in_byte;
						next_state.opcode_valid = known_op;
						next_state.phase = known_op ? SFS_ACTIVE : SFS_REJECT;
						next_state.wsr_ok = (in_byte == `SFS_OP_WR_STATUS) &
							~guarded;
						next_state.read_req = 1'b1;
						next_state.shift_out = state.status;
					end else begin
						next_state.byte_data = in_byte;
						next_state.byte_valid = 1'b1;
						next_state.read_req = 1'b1;
						if (state.opcode == `SFS_OP_WR_STATUS && !state.wsr_got) begin
							next_state.wsr_got = 1'b1;
						end
						next_state.shift_out = (state.opcode == `SFS_OP_RD_STATUS) ?
							state.status : read_data_in;
					end
				end
			end
			if (sck_fall && state.phase == SFS_ACTIVE) begin
				next_state.out_bit = state.shift_out[7];
				next_state.shift_out = {state.shift_out[6:0], 1'b0};
				next_state.out_en = 1'b1;
			end
			if (state.phase == SFS_REJECT) begin
				next_state.out_en = 1'b0;
			end
		end
		// pin fall while selected abandons the write when the enable bit is set, paused or not
		if (~sel_n && guard_fall && state.status[`SFS_GUARD_EN_BIT] &&
		    state.opcode == `SFS_OP_WR_STATUS) begin
			next_state.wsr_ok = 1'b0;
		end
		// bit count, shift state and opcode held unchanged during pause
		if (state.status_write) begin
			next_state.status = (state.status & ~`SFS_STATUS_WMASK) |
				(state.byte_data & `SFS_STATUS_WMASK);
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '{sck_prev: 1'b0, sel_prev: 1'b1, pause_prev: 1'b1,
				guard_prev: 1'b1, phase: SFS_OPCODE,
				status: `SFS_STATUS_RESET, default: '0};
		end else begin
			state <= next_state;
		end
	end

	assign serial_out_out = state.out_bit;
	// float while deselected, paused or rejected
	assign serial_out_oe_out = state.out_en & ~sel_n & ~state.paused;
	assign opcode_out = state.opcode;
	assign opcode_valid_out = state.opcode_valid;
	assign byte_out = state.byte_data;
	assign byte_valid_out = state.byte_valid;
	assign read_req_out = state.read_req;
	assign status_out = state.status;
	assign status_write_out = state.status_write;
	assign paused_out = state.paused;

	property p_deselect_float;
		@(posedge clock_in) disable iff (rst_in)
		sel_n |=> (!state.out_en && !serial_out_oe_out);
	endproperty
	a_deselect_float: assert property (p_deselect_float)
		else $error("serial_out driven while deselected");

	property p_pause_float;
		@(posedge clock_in) disable iff (rst_in)
		state.paused |-> !serial_out_oe_out;
	endproperty
	a_pause_float: assert property (p_pause_float)
		else $error("serial_out driven during pause");

	property p_pause_keeps;
		@(posedge clock_in) disable iff (rst_in)
		(state.paused && !sel_n) |=> $stable(state.bit_count);
	endproperty
	a_pause_keeps: assert property (p_pause_keeps)
		else $error("bit position changed during pause");

	property p_reject_quiet;
		@(posedge clock_in) disable iff (rst_in)
		(state.phase == SFS_REJECT && !sel_n && !sel_fall)
			|=> $stable(state.shift_in);
	endproperty
	a_reject_quiet: assert property (p_reject_quiet)
		else $error("input accepted after invalid opcode");

	property p_deselect_clear;
		@(posedge clock_in) disable iff (rst_in)
		sel_n |=> (state.bit_count == 3'h0 && state.phase == SFS_OPCODE);
	endproperty
	a_deselect_clear: assert property (p_deselect_clear)
		else $error("deselect did not clear command state");

	property p_guard_block;
		@(posedge clock_in) disable iff (rst_in)
		(state.opcode_valid && state.opcode == `SFS_OP_WR_STATUS &&
		 $past(guarded)) |-> !state.wsr_ok;
	endproperty
	a_guard_block: assert property (p_guard_block)
		else $error("status write allowed while guarded");

	property p_pause_enter;
		@(posedge clock_in) disable iff (rst_in)
		(!sel_n && !pause_n && !sck) |=> state.paused;
	endproperty
	a_pause_enter: assert property (p_pause_enter)
		else $error("pause not entered with clock low");

	property p_pause_leave;
		@(posedge clock_in) disable iff (rst_in)
		(!sel_n && pause_n && !sck) |=> !state.paused;
	endproperty
	a_pause_leave: assert property (p_pause_leave)
		else $error("pause not left with clock low");

	property p_reject_float;
		@(posedge clock_in) disable iff (rst_in)
		(state.phase == SFS_REJECT) |-> !serial_out_oe_out;
	endproperty
	a_reject_float: assert property (p_reject_float)
		else $error("serial_out driven after invalid opcode");

	property p_opcode_active;
		@(posedge clock_in) disable iff (rst_in)
		state.opcode_valid |-> (state.phase == SFS_ACTIVE);
	endproperty
	a_opcode_active: assert property (p_opcode_active)
		else $error("valid opcode did not start the command");

	property p_take_bit;
		@(posedge clock_in) disable iff (rst_in)
		(sck_rise && shifting && !sel_fall && state.phase != SFS_REJECT)
			|=> (state.shift_in[0] == $past(sin));
	endproperty
	a_take_bit: assert property (p_take_bit)
		else $error("serial_in not taken at clock rise");

	property p_count_bit;
		@(posedge clock_in) disable iff (rst_in)
		(sck_rise && shifting && !sel_fall && state.phase != SFS_REJECT)
			|=> (state.bit_count == $past(state.bit_count) + 3'h1);
	endproperty
	a_count_bit: assert property (p_count_bit)
		else $error("bit position not advanced at clock rise");

	property p_shift_out;
		@(posedge clock_in) disable iff (rst_in)
		(sck_fall && shifting && !sel_fall && state.phase == SFS_ACTIVE)
			|=> (state.out_bit == $past(state.shift_out[7]));
	endproperty
	a_shift_out: assert property (p_shift_out)
		else $error("output bit not shifted at clock fall");

	property p_deselect_quiet;
		@(posedge clock_in) disable iff (rst_in)
		sel_n |=> (!state.opcode_valid && !state.byte_valid);
	endproperty
	a_deselect_quiet: assert property (p_deselect_quiet)
		else $error("serial activity taken while deselected");

	property p_write_commit;
		@(posedge clock_in) disable iff (rst_in)
		(sel_n && state.wsr_got && state.wsr_ok) |=> state.status_write;
	endproperty
	a_write_commit: assert property (p_write_commit)
		else $error("complete status write not committed");

	property p_guard_abandon;
		@(posedge clock_in) disable iff (rst_in)
		(!sel_n && guard_fall && state.status[`SFS_GUARD_EN_BIT] &&
		 state.opcode == `SFS_OP_WR_STATUS) |=> !state.wsr_ok;
	endproperty
	a_guard_abandon: assert property (p_guard_abandon)
		else $error("status write kept after guard pin fall");
endmodule : sfs_front
`default_nettype wire

// ===== sfs_consts.svh
// Purpose: constants of the serial flash slave front end
// Assumes: included by package and modules by bare name
// Notes:   definitions only
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_OP_WR_ENABLE  8'h06
`define SFS_OP_WR_DISABLE 8'h04
`define SFS_OP_RD_STATUS  8'h05
`define SFS_OP_WR_STATUS  8'h01
`define SFS_OP_READ       8'h03
`define SFS_OP_FAST_READ  8'h0B
`define SFS_OP_PROGRAM    8'h02
`define SFS_OP_PAGE_ERASE 8'h81
`define SFS_OP_SECT_ERASE 8'hD8
`define SFS_OP_BULK_ERASE 8'hC7
`define SFS_OP_SW_PROTECT 8'hB9
`define SFS_OP_RELEASE    8'hAB
`define SFS_GUARD_EN_BIT  7
`define SFS_WEN_BIT       1
`define SFS_BUSY_BIT      0
`define SFS_STATUS_RESET  8'h00
`define SFS_STATUS_WMASK  8'h8C
// idle pin levels: select, serial clock, data, pause, guard
`define SFS_PIN_IDLE      5'h13
`endif

// ===== sfs_pkg.sv
// Purpose: types of the serial flash slave front end
// Assumes: sfs_consts.svh holds the numbers
// Notes:   none
`include "sfs_consts.svh"
package sfs_pkg;
	typedef enum logic [1:0] {
		SFS_OPCODE,
		SFS_ACTIVE,
		SFS_REJECT
	} sfs_phase_type;
endpackage : sfs_pkg

// ===== sfs_sync.sv
// Purpose: two-flop synchroniser for the five pins of the link
// Assumes: inputs are asynchronous to clock_in
// Notes:   reset value is the idle pin level
`timescale 1ns/100ps
`default_nettype none
module sfs_sync #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	// pins
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sfs_sync_state_type;

	sfs_sync_state_type state;
	sfs_sync_state_type next_state;

	always_comb begin
		next_state.first = async_in;
		next_state.second = state.first;
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state <= {IDLE, IDLE};
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.second;
endmodule : sfs_sync
`default_nettype wire

// ===== sfs_master.sv
// Purpose: bus master model driving the serial link of the front end
// Assumes: link pins are asynchronous to the design clock
// Notes:   160 ns serial clock period, mode 0 or mode 3
`timescale 1ns/100ps
`default_nettype none
module sfs_master (
	// link pins driven
	output logic      device_select_n_out,
	output logic      serial_clock_out,
	output logic      serial_in_out,
	output logic      pause_n_out,
	output logic      write_guard_n_out,
	// link pins seen
	input  wire logic serial_out_in,
	input  wire logic serial_out_oe_in
);
	logic       cpol;
	logic [7:0] rx;
	initial begin
		cpol = 1'b0;
		rx = 8'h00;
		device_select_n_out = 1'b1;
		serial_clock_out = 1'b0;
		serial_in_out = 1'b0;
		pause_n_out = 1'b1;
		write_guard_n_out = 1'b1;
	end
	// clock rests at the mode's idle level between frames
	task automatic idle(input logic pol);
		cpol = pol;
		serial_clock_out = pol;
		#200;
	endtask : idle
	task automatic sel();
		device_select_n_out = 1'b0;
		// lets the front end see select fall before the first clock edge
		#180;
	endtask : sel
	// never deselects while pause_n is low
	task automatic desel();
		serial_clock_out = cpol;
		#100;
		device_select_n_out = 1'b1;
		serial_in_out = ~serial_in_out;
		#200;
	endtask : desel
	// n bits from the top of tx, msb first; reads just before the fall
	task automatic bits(input logic [7:0] tx, input int n);
		for (int i = 0; i < n; i++) begin
			serial_clock_out = 1'b0;
			serial_in_out = tx[7-i];
			#80 serial_clock_out = 1'b1;
			#79 rx = {rx[6:0], serial_out_oe_in ? serial_out_in : 1'bx};
			#1;
		end
	endtask : bits
	// pause only ever moved while selected
	task automatic pins(input logic p, input logic g);
		pause_n_out = p;
		write_guard_n_out = g;
		#100;
	endtask : pins
endmodule : sfs_master
`default_nettype wire

// ===== test_serial_flash_spi_slave_front_end.sv
// Purpose: self-checking bench of the serial flash front end
// Assumes: master model drives the link pins
// Notes:   status model keeps the writable bits only
`timescale 1ns/100ps
`default_nettype none
module test_serial_flash_spi_slave_front_end;
	import sfs_pkg::*;
	logic       clock_in, rst_in, busy_in, oe, so, pv, ov, sw, bv, rq;
	logic [7:0] read_data_in, op, sto, bo;
	wire        cs_n, sck, si, pn, wg;
	int         failures, cmp_count, st, wr_seen, wr_exp, seed;
	int         rq_seen, rq_exp;
	int         exp_op[$];
	logic [7:0] exp_byte[$];
	sfs_front uut (.clock_in(clock_in), .rst_in(rst_in),
		.device_select_n_in(cs_n), .serial_clock_in(sck),
		.serial_in_in(si), .pause_n_in(pn), .write_guard_n_in(wg),
		.serial_out_out(so), .serial_out_oe_out(oe), .busy_in(busy_in),
		.read_data_in(read_data_in), .opcode_out(op),
		.opcode_valid_out(ov), .byte_out(bo), .byte_valid_out(bv),
		.read_req_out(rq), .status_out(sto), .status_write_out(sw),
		.paused_out(pv));
	sfs_master m (.device_select_n_out(cs_n), .serial_clock_out(sck),
		.serial_in_out(si), .pause_n_out(pn), .write_guard_n_out(wg),
		.serial_out_in(so), .serial_out_oe_in(oe));
	always #10 clock_in = ~clock_in;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask : chk
	always @(negedge clock_in) begin
		if (ov === 1'b1)
			chk(op, exp_op.size() ? 8'(exp_op.pop_front()) : 8'hEE);
		if (sw === 1'b1)
			wr_seen++;
		if (bv === 1'b1)
			chk(bo, exp_byte.size() ? exp_byte.pop_front() : 8'hEE);
		if (rq === 1'b1)
			rq_seen++;
	end
	task automatic cmd(input logic [7:0] o, input logic ok);
		rq_exp++;
		m.sel();
		if (ok)
			exp_op.push_back(o);
		m.bits(o, 8);
	endtask : cmd
	task automatic rdsr();
		logic [7:0] r;
		r = 8'($urandom);
		cmd(8'h05, 1);
		exp_byte.push_back(r);
		rq_exp++;
		m.bits(r, 8);
		chk(m.rx & 8'hFD, 8'(st) | {7'h00, busy_in});
		chk(sto & 8'hFD, 8'(st) | {7'h00, busy_in});
		m.desel();
		chk({7'h00, oe}, 8'h00);
	endtask : rdsr
	// array read: address byte, then the core's byte shifts out
	task automatic rd();
		logic [7:0] a;
		a = 8'($urandom);
		cmd(8'h03, 1);
		exp_byte.push_back(a);
		exp_byte.push_back(~a);
		rq_exp += 2;
		m.bits(a, 8);
		m.bits(~a, 8);
		chk(m.rx, read_data_in);
		m.desel();
	endtask : rd
	// how: 0 plain, 1 guard falls mid data, 2 pause mid data
	task automatic wrsr(input logic [7:0] d, input logic ok, input int how);
		cmd(8'h06, 1);
		m.desel();
		cmd(8'h01, 1);
		exp_byte.push_back(d);
		rq_exp++;
		m.bits(d, 4);
		if (how == 1)
			m.pins(1'b1, 1'b0);
		if (how == 2) begin
			m.pins(1'b0, 1'b1);
			m.bits(8'($urandom), 8);
			chk({7'h00, pv}, 8'h01);
			chk({7'h00, oe}, 8'h00);
			m.pins(1'b1, 1'b1);
		end
		m.bits({d[3:0], 4'h0}, 4);
		m.desel();
		if (ok) begin
			st = d & 8'h8C;
			wr_exp++;
		end
		rdsr();
	endtask : wrsr
	task automatic end_sim();
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (100000) @(posedge clock_in);
		failures++;
		end_sim();
	end
	initial begin
		clock_in = 1'b0;
		rst_in = 1'b1;
		busy_in = 1'b0;
		failures = 0;
		cmp_count = 0;
		st = 0;
		wr_seen = 0;
		wr_exp = 0;
		rq_seen = 0;
		rq_exp = 0;
		seed = $urandom(33);
		read_data_in = 8'($urandom);
		repeat (2) @(posedge clock_in);
		@(negedge clock_in) rst_in = 1'b0;
		chk(sto, 8'h00);
		chk({7'h00, oe}, 8'h00);
		for (int md = 0; md < 2; md++) begin
			m.idle(md[0]);
			wrsr(8'($urandom) & 8'h7F, 1, 0);
			wrsr(8'($urandom) & 8'h7F, 1, 2);
			rd();
		end
		@(negedge clock_in) busy_in = 1'b1;
		rdsr();
		@(negedge clock_in) busy_in = 1'b0;
		wrsr(8'h84, 1, 0);
		m.pins(1'b1, 1'b0);
		wrsr(8'h08, 0, 0);
		m.pins(1'b1, 1'b1);
		wrsr(8'h08, 0, 1);
		m.pins(1'b1, 1'b1);
		wrsr(8'h88, 1, 0);
		m.pins(1'b1, 1'b0);
		rdsr();
		m.pins(1'b1, 1'b1);
		wrsr(8'h00, 1, 0);
		m.pins(1'b1, 1'b0);
		wrsr(8'h0C, 1, 0);
		m.pins(1'b1, 1'b1);
		cmd(8'hFF, 0);
		m.bits(8'h05, 8);
		chk({7'h00, oe}, 8'h00);
		m.desel();
		m.sel();
		m.bits(8'h05, 3);
		m.desel();
		rdsr();
		chk(8'(exp_op.size()), 8'h00);
		chk(8'(wr_seen), 8'(wr_exp));
		chk(8'(exp_byte.size()), 8'h00);
		chk(8'(rq_seen), 8'(rq_exp));
		end_sim();
	end
endmodule : test_serial_flash_spi_slave_front_end
`default_nettype wire
